// File: design/sio_hold_timers.sv
// Per-output timeout hold timers
`timescale 1ns/10ps
module sio_hold_timers #(
  parameter int unsigned N = 8,
  parameter int unsigned W = 16
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link to the override logic
  sio_tmr_if.tmr t
);

  logic [W-1:0] cnt [N];
  logic [N-1:0] busy;

  // ==========================================================
  // Counters
  // Reloaded while requested, count down after release; run low
  // freezes every counter so the output level cannot move.
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (rst)
        cnt[i] <= '0;
      else if (t.run && t.hold_req[i])
        cnt[i] <= t.len[i];
      else if (t.run && busy[i])
        cnt[i] <= cnt[i] - W'(1);
    end
  end

  // ==========================================================
  // Asserted while requested or timeout still running
  always_comb
  begin
    for (int i = 0; i < N; i++)
      busy[i] = (cnt[i] != '0);
  end

  assign t.asserted = t.hold_req | busy; // [RULE5]

endmodule

// File: design/sio_override.sv
// Input conditioning, manual reset and margin override for sequenced outputs
// Behaviour
// RULE1: polarity bit selects each general input's active level
// RULE2: auxiliary inputs never assert any output
// RULE3: manual reset low starts a reset condition
// RULE4: manual reset asserts outputs selected by mask
// RULE5: released outputs hold for their own timeout
// RULE6: manual reset never sole output dependency; the code still drives such outputs and only flags them in cfg_mr_only
// RULE7: margin low holds or forces each output
// RULE8: margin level bit picks forced low or high
// RULE9: outputs frozen while margin is low
// RULE10: converter keeps scanning during margin
// RULE11: margin wins over simultaneous manual reset
// RULE12: reference select bit zero picks internal/external
// RULE13: asserted level follows output active polarity
// RULE14: pins synchronised before the output logic uses them
`timescale 1ns/10ps
module sio_override #(
  parameter int unsigned N = sio_pkg::NUM_OUT,
  parameter int unsigned W = sio_pkg::TMO_W
)(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Pins from the board
  input wire logic [3:0] general_logic_inputs,
  input wire logic manual_reset_n,
  input wire logic margin_n,
  // Register port from the serial interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Dependency logic and output configuration
  input wire logic [N-1:0] dep_assert,
  input wire logic [N-1:0] dep_has_condition,
  input wire logic [N-1:0] po_active_high,
  input wire logic [N*W-1:0] po_timeout_len,
  // Results
  output logic [N-1:0] sequenced_output,
  output logic [3:0] gpi_active,
  output logic mr_active,
  output logic margin_active,
  output logic ref_use_external,
  output logic adc_scan_run,
  output logic [N-1:0] cfg_mr_only
);

  // ==========================================================
  // Helpers
  function automatic logic [N-1:0] pin_level(input logic [N-1:0] asrt,
                                             input logic [N-1:0] hi);
    pin_level = ~(asrt ^ hi); // [RULE13]
  endfunction

  // ==========================================================
  // Pin synchronisers
  // Three stages; a change is taken only when stages two and three
  // agree, which also rejects a single-cycle glitch at the pin.
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_s3;
  logic [5:0] pin_q;
  logic [5:0] pin_raw;
  logic [5:0] pin_agree;

  assign pin_raw = {margin_n, manual_reset_n, general_logic_inputs};
  assign pin_agree = ~(pin_s2 ^ pin_s3);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_s1 <= sio_pkg::RST_PINS;
      pin_s2 <= sio_pkg::RST_PINS;
      pin_s3 <= sio_pkg::RST_PINS;
      pin_q <= sio_pkg::RST_PINS;
    end
    else if (ce)
    begin
      pin_s1 <= pin_raw; // [RULE14]
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q <= (pin_s3 & pin_agree) | (pin_q & ~pin_agree); // [RULE14]
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] gp_input_polarity;
  logic [7:0] manual_reset_output_mask;
  logic [7:0] margin_hold_or_force;
  logic [7:0] margin_forced_level;
  logic [7:0] reference_select;

  // Writes gated by ce so a frozen block ignores the bus too
  wire wr_pol = ce && reg_wr && (reg_addr == sio_pkg::OFS_GPI_POL);
  wire wr_mask = ce && reg_wr && (reg_addr == sio_pkg::OFS_MR_MASK);
  wire wr_mode = ce && reg_wr && (reg_addr == sio_pkg::OFS_MG_MODE);
  wire wr_lvl = ce && reg_wr && (reg_addr == sio_pkg::OFS_MG_LEVEL);
  wire wr_ref = ce && reg_wr && (reg_addr == sio_pkg::OFS_REF_SEL);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      gp_input_polarity <= sio_pkg::RST_GPI_POL;
      manual_reset_output_mask <= sio_pkg::RST_MR_MASK;
      margin_hold_or_force <= sio_pkg::RST_MG_MODE;
      margin_forced_level <= sio_pkg::RST_MG_LEVEL;
      reference_select <= sio_pkg::RST_REF_SEL;
    end
    else
    begin
      if (wr_pol)
        gp_input_polarity <= {4'h0, reg_wdata[3:0]};
      if (wr_mask)
        manual_reset_output_mask <= reg_wdata;
      if (wr_mode)
        margin_hold_or_force <= reg_wdata;
      if (wr_lvl)
        margin_forced_level <= reg_wdata;
      if (wr_ref)
        reference_select <= {7'h00, reg_wdata[0]}; // [RULE12]
    end
  end

  // ==========================================================
  // Read decode
  logic [7:0] status_word;
  logic [7:0] next_rdata;

  assign status_word = {gpi_active, 1'b0, ref_use_external,
                        margin_active, mr_active};

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      sio_pkg::OFS_GPI_POL: next_rdata = gp_input_polarity;
      sio_pkg::OFS_MR_MASK: next_rdata = manual_reset_output_mask;
      sio_pkg::OFS_MG_MODE: next_rdata = margin_hold_or_force;
      sio_pkg::OFS_MG_LEVEL: next_rdata = margin_forced_level;
      sio_pkg::OFS_REF_SEL: next_rdata = reference_select;
      sio_pkg::OFS_STATUS: next_rdata = status_word;
      sio_pkg::OFS_CFG_ERR: next_rdata = cfg_mr_only;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (ce && reg_rd)
      reg_rdata <= next_rdata;
  end

  // ==========================================================
  // Conditioned inputs
  // Auxiliary monitor inputs are measured elsewhere and have no
  // path into this block at all. [RULE2]
  wire [3:0] next_gpi = pin_q[3:0] ^ ~gp_input_polarity[3:0]; // [RULE1]
  wire mr_low = ~pin_q[sio_pkg::PIN_MR_BIT]; // [RULE3]
  wire mg_low = ~pin_q[sio_pkg::PIN_MG_BIT];
  wire mr_effective = mr_low & ~mg_low; // [RULE11]

  // ==========================================================
  // Hold timers
  sio_tmr_if #(.N(N), .W(W)) tmr_bus ();

  assign tmr_bus.run = ce & ~mg_low; // [RULE9]
  assign tmr_bus.hold_req = dep_assert |
    ({N{mr_effective}} & manual_reset_output_mask[N-1:0]); // [RULE4]
  assign tmr_bus.len = po_timeout_len;

  sio_hold_timers #(.N(N), .W(W)) u_timers (
    .core_clk(core_clk),
    .rst(rst),
    .t(tmr_bus.tmr)
  );

  // ==========================================================
  // Output level selection
  logic [N-1:0] normal_level;
  logic [N-1:0] margin_level;
  logic [N-1:0] next_out;

  assign normal_level = pin_level(tmr_bus.asserted, po_active_high);
  // Forced margin level is a raw pin level, not an asserted state
  assign margin_level = (margin_hold_or_force[N-1:0] &
                         margin_forced_level[N-1:0]) |
                        (~margin_hold_or_force[N-1:0] &
                         sequenced_output); // [RULE7] [RULE8]
  assign next_out = mg_low ? margin_level : normal_level; // [RULE9]

  // Configuration check: a mask bit with no other dependency.
  wire [N-1:0] next_cfg_err = manual_reset_output_mask[N-1:0] &
                              ~dep_has_condition; // [RULE6]

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sequenced_output <= pin_level({N{1'b1}}, po_active_high);
      gpi_active <= 4'h0;
      mr_active <= 1'b0;
      margin_active <= 1'b0;
      ref_use_external <= 1'b0;
      adc_scan_run <= 1'b0;
      cfg_mr_only <= '0;
    end
    else if (ce)
    begin
      sequenced_output <= next_out;
      gpi_active <= next_gpi;
      mr_active <= mr_low;
      margin_active <= mg_low;
      ref_use_external <= reference_select[sio_pkg::REF_EXT_BIT]; // [RULE12]
      // Scanning is independent of margin by design. [RULE10]
      adc_scan_run <= 1'b1;
      cfg_mr_only <= next_cfg_err;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Antecedents carry ce, except chk_scan_runs and chk_ce_freeze (which takes !ce): a frozen cycle moves nothing

  chk_gpi_polarity: assert property ( // [RULE1]
    ce |=> gpi_active == ($past(pin_q[3:0]) ^ ~$past(gp_input_polarity[3:0])))
    else $error("general input active level wrong");

  chk_mr_forces: assert property ( // [RULE4]
    (ce && mr_low && !mg_low) |=>
      ((~(sequenced_output ^ po_active_high) &
        $past(manual_reset_output_mask[N-1:0])) ==
       $past(manual_reset_output_mask[N-1:0]) || $past(po_active_high)
       != po_active_high))
    else $error("masked output not asserted during manual reset");

  chk_mr_release_hold: assert property ( // [RULE5]
    (ce && !mg_low && !$past(mg_low) && $fell(mr_low) &&
      manual_reset_output_mask[0] && po_timeout_len[W-1:0] > W'(2))
      ##1 ce |-> tmr_bus.asserted[0])
    else $error("output released before its timeout");

  chk_sync_delay: assert property ( // [RULE14] [RULE3]
    (ce && !manual_reset_n) [*4] |=> mr_low)
    else $error("manual reset not taken after sync delay");

  chk_margin_force: assert property ( // [RULE7] [RULE8]
    (ce && mg_low) |=> ((sequenced_output ^ $past(margin_forced_level))
      & $past(margin_hold_or_force)) == '0)
    else $error("forced margin level not driven");

  chk_margin_freeze: assert property ( // [RULE9]
    (ce && mg_low) ##1 (ce && mg_low) |=>
      ((sequenced_output ^ $past(sequenced_output)) &
       ~$past(margin_hold_or_force)) == '0)
    else $error("held output changed during margin");

  chk_margin_over_mr: assert property ( // [RULE11]
    (ce && mg_low && mr_low) |=>
      ((sequenced_output ^ $past(sequenced_output)) &
       ~$past(margin_hold_or_force[N-1:0])) == '0)
    else $error("manual reset acted while margin low");

  chk_scan_runs: assert property ( // [RULE10]
    (margin_active && $past(margin_active)) |-> adc_scan_run)
    else $error("converter stopped during margin");

  chk_ref_select: assert property ( // [RULE12]
    wr_ref ##1 ce |=> ref_use_external == $past(reg_wdata[0], 2))
    else $error("reference select not applied");

  chk_out_polarity: assert property ( // [RULE13]
    (ce && !mg_low) |=> sequenced_output ==
      ~($past(tmr_bus.asserted) ^ $past(po_active_high)))
    else $error("output level ignores active polarity");

  chk_cfg_pair: assert property ( // [RULE6]
    ce |=> cfg_mr_only == $past(manual_reset_output_mask[N-1:0] &
      ~dep_has_condition))
    else $error("manual-reset-only flag wrong");

  // A low enable must leave the output, general input, manual reset and margin results where they were
  chk_ce_freeze: assert property ( // [RULE14]
    !ce |=> $stable(sequenced_output) && $stable(gpi_active)
      && $stable(mr_active) && $stable(margin_active))
    else $error("state moved while clock enable low");

  cov_mr_assert: cover property (ce && mr_low && !mg_low
    && manual_reset_output_mask != 8'h00);
  cov_mr_release: cover property ($fell(mr_low) && tmr_bus.asserted != '0);
  cov_margin_force: cover property (mg_low && margin_hold_or_force != 8'h00);
  cov_margin_with_mr: cover property (mg_low && mr_low);
  cov_ce_frozen: cover property (!ce && pin_raw != pin_s1);

endmodule

// File: design/sio_pkg.sv
// Shared constants for the sequencer input override logic
package sio_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NUM_OUT = 8;
  localparam int unsigned NUM_GPI = 4;
  localparam int unsigned TMO_W = 16;
  localparam int unsigned PIN_W = 6;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_GPI_POL = 8'h3B;
  localparam logic [7:0] OFS_MR_MASK = 8'h40;
  localparam logic [7:0] OFS_MG_MODE = 8'h41;
  localparam logic [7:0] OFS_MG_LEVEL = 8'h42;
  localparam logic [7:0] OFS_REF_SEL = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam logic [7:0] OFS_CFG_ERR = 8'h49;

  // ==========================================================
  // Field positions
  localparam int unsigned REF_EXT_BIT = 0;
  localparam int unsigned ST_MR_BIT = 0;
  localparam int unsigned ST_MG_BIT = 1;
  localparam int unsigned ST_REF_BIT = 2;
  localparam int unsigned ST_GPI_LSB = 4;
  localparam int unsigned PIN_MR_BIT = 4;
  localparam int unsigned PIN_MG_BIT = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_GPI_POL = 8'h00;
  localparam logic [7:0] RST_MR_MASK = 8'h00;
  localparam logic [7:0] RST_MG_MODE = 8'h00;
  localparam logic [7:0] RST_MG_LEVEL = 8'h00;
  localparam logic [7:0] RST_REF_SEL = 8'h00;
  localparam logic [5:0] RST_PINS = 6'h30;

endpackage

// File: design/sio_tmr_if.sv
// Carrier between the override logic and its hold timers
`timescale 1ns/10ps
interface sio_tmr_if #(
  parameter int unsigned N = 8,
  parameter int unsigned W = 16
);
  logic run;
  logic [N-1:0] hold_req;
  logic [N-1:0][W-1:0] len;
  logic [N-1:0] asserted;

  modport ctl (output run, output hold_req, output len, input asserted);
  modport tmr (input run, input hold_req, input len, output asserted);
endinterface

// File: testbench/sio_board.sv
// Board-side model driving the sequencer's pins
`timescale 1ns/10ps
module sio_board (
  // Clock
  input wire logic core_clk,
  // Pins toward the device
  output logic [3:0] gpi,
  output logic mr_n,
  output logic mg_n
);
  // ==========================================================
  // Idle levels: controls pulled up, general inputs pulled down
  initial
  begin
    gpi = 4'h0;
    mr_n = 1'b1;
    mg_n = 1'b1;
  end

  // ==========================================================
  // Levels change just after an edge, held until the next call
  task automatic pins(input logic [3:0] g, input logic m, input logic k);
    @(posedge core_clk);
    #1;
    gpi = g;
    mr_n = m;
    mg_n = k;
  endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the sequencer input override logic
`timescale 1ns/10ps
`define SIO_CMP(got, exp) \
  begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); end end
module testbench;
  typedef struct {logic [2:0] s; logic [7:0] v;} sio_tb_note_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] dep_assert = 8'h00;
  logic [7:0] dep_has = 8'hFF;
  logic [7:0] po_hi = 8'hA5;
  logic [127:0] tlen = {8{16'h0003}};
  logic [7:0] seq_out, cfg_mr_only;
  logic [3:0] gpi, gpi_active;
  logic mr_n, mg_n, mr_active, margin_active, ref_ext, adc_run;
  logic look = 1'b0;
  logic ce = 1'b1;
  logic [7:0] gpi_word, flag_word;
  sio_tb_note_t q[$];
  sio_tb_note_t nt;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] ofs[5] = '{8'h3B, 8'h40, 8'h41, 8'h42, 8'h44};
  logic [7:0] msk[5] = '{8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h01};
  logic [7:0] d, pol, ex;

  always #10 core_clk = ~core_clk;

  sio_board i_sio_board (.core_clk(core_clk), .gpi(gpi), .mr_n(mr_n),
    .mg_n(mg_n));
  assign gpi_word = {4'h0, gpi_active};
  assign flag_word = {5'h0, ref_ext, adc_run, margin_active};

  sio_override i_sio_override (.core_clk(core_clk), .rst(rst), .ce(ce),
    .general_logic_inputs(gpi), .manual_reset_n(mr_n), .margin_n(mg_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dep_assert(dep_assert),
    .dep_has_condition(dep_has), .po_active_high(po_hi),
    .po_timeout_len(tlen), .sequenced_output(seq_out),
    .gpi_active(gpi_active), .mr_active(mr_active),
    .margin_active(margin_active), .ref_use_external(ref_ext),
    .adc_scan_run(adc_run), .cfg_mr_only(cfg_mr_only));

  // ==========================================================
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic expect_out(input logic [2:0] s, input logic [7:0] v);
    q.push_back(sio_tb_note_t'{s, v});
    look = 1'b1;
    step(1);
    look = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    expect_out(3'h0, v);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Watcher: oldest note against the output it names
  always @(negedge core_clk)
  begin
    if (look)
    begin
      nt = q.pop_front();
      case (nt.s)
        3'h0: `SIO_CMP(reg_rdata, nt.v)
        3'h1: `SIO_CMP(seq_out, nt.v)
        3'h2: `SIO_CMP(gpi_word, nt.v)
        3'h3: `SIO_CMP(cfg_mr_only, nt.v)
        default: `SIO_CMP(flag_word, nt.v)
      endcase
    end
  end

  // Hang guard, generous against some 190 cycles of tests
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(90));
    step(5);
    rst = 1'b0;
    expect_out(3'h1, po_hi);
    step(2);
    expect_out(3'h4, 8'h02);
    for (int i = 0; i < 5; i++)
    begin
      d = 8'($urandom());
      rd(ofs[i], 8'h00);
      wr(ofs[i], d);
      rd(ofs[i], d & msk[i]);
    end
    wr(8'h50, 8'hAA);
    rd(8'h50, 8'h00);
    wr(8'h44, 8'h01);
    step(2);
    expect_out(3'h4, 8'h06);
    wr(8'h44, 8'hFE);
    step(2);
    expect_out(3'h4, 8'h02);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      pol = 8'($urandom());
      d = 8'($urandom());
      wr(8'h3B, pol);
      i_sio_board.pins(d[3:0], 1'b1, 1'b1);
      step(5);
      expect_out(3'h2, {4'h0, ~(d[3:0] ^ pol[3:0])});
    end
    $display("test polarity done");
    // Deassert everything first so the mask effect is visible
    po_hi = 8'($urandom());
    wr(8'h3B, 8'h0F);
    wr(8'h41, 8'h00);
    i_sio_board.pins(4'h0, 1'b1, 1'b1);
    step(20);
    expect_out(3'h1, ~po_hi);
    wr(8'h40, 8'h5B);
    i_sio_board.pins(4'h0, 1'b0, 1'b1);
    step(5);
    expect_out(3'h1, ~(8'h5B ^ po_hi));
    rd(8'h48, 8'h01);
    i_sio_board.pins(4'h0, 1'b1, 1'b1);
    step(7);
    expect_out(3'h1, ~(8'h5B ^ po_hi));
    expect_out(3'h1, ~po_hi);
    $display("test manual reset done");
    wr(8'h41, 8'h0F);
    wr(8'h42, 8'h05);
    ex = {~po_hi[7:4], 4'h5};
    i_sio_board.pins(4'h0, 1'b1, 1'b0);
    step(5);
    expect_out(3'h1, ex);
    dep_assert = 8'hFF;
    i_sio_board.pins(4'h0, 1'b0, 1'b0);
    step(8);
    expect_out(3'h1, ex);
    expect_out(3'h4, 8'h03);
    i_sio_board.pins(4'h0, 1'b1, 1'b1);
    step(8);
    expect_out(3'h1, po_hi);
    $display("test margin done");
    ce = 1'b0;
    i_sio_board.pins(4'hF, 1'b1, 1'b1);
    step(8);
    expect_out(3'h2, 8'h00);
    ce = 1'b1;
    step(5);
    expect_out(3'h2, 8'h0F);
    $display("test clock enable done");
    wr(8'h40, 8'hFF);
    dep_has = 8'h3C;
    step(3);
    expect_out(3'h3, 8'hC3);
    rd(8'h49, 8'hC3);
    $display("test mr only done");
    report_and_stop();
  end
endmodule
